// >>> crsd_core.v
// register section datapath and cycle sequencer of an 8-bit processor
`timescale 1ns/10ps
`include "crsd_regs.vh"
// Overview of operation
// - cycle state forced to first state on fetch, advances at end of phase two
// - states step per cycle; transfers decoded from opcode and state
// - opcode from data bus captured into instruction register, then decoded
// - bus data captured in phase two into latch, used next cycle
// - internal register and alu transfers all happen in phase one
// - alu holds nothing; result written to a register next cycle
// - each alu bit takes two selectable inputs or zero; sum, and, or, eor
// - alu steps registers; program counter has its own incrementer
// - fetch drives program counter low byte low, high byte high
// - program counter increments on every opcode or operand fetch
// - accumulator is eight bits, supplies and receives most alu operands
// - stack pointer and two index registers are eight plain latches
// - address latches hold current address; always a meaningful address
// - address launched in phase one, held until next phase one
// - reduced variants drive only thirteen or twelve address lines
// - upper address bits simply not driven, so accesses alias
// - status latches control operation and record alu result flags
// - control combines status latches with decoded opcode for sequencing
// - data bus released in phase one, driven only in phase two
// - read/write high except writes, changes only in phase one
module crsd_core #(
   parameter ADDR_W = 16,
   parameter [15:0] RESET_PC = `PC_RESET
) (
   // clock and reset
   input wire clk,
   input wire nrst,
   // system bus
   output wire [ADDR_W-1:0] address_lines,
   output wire bus_read,
   input wire [7:0] data_in,
   output wire [7:0] data_out,
   output wire data_oe_n,
   // cycle timing
   output wire phase_two,
   output wire fetch_cycle
);

   reg rs1_r;
   reg rs2_r;
   wire rst_n;
   reg ph_r;
   reg phi2_r;
   reg [2:0] t_r;
   reg end_r;
   reg [7:0] ir_r;
   reg [7:0] input_capture_latch;
   reg [7:0] fetch_pointer_low;
   reg [7:0] fetch_pointer_high;
   reg [7:0] acc_r;
   reg [7:0] idx_x_r;
   reg [7:0] idx_y_r;
   reg [7:0] stk_r;
   reg [7:0] p_r;
   reg [7:0] lo_r;
   reg [7:0] ai_r;
   reg [7:0] bi_r;
   reg cin_r;
   reg [1:0] op_r;
   reg [2:0] dst_r;
   reg fnz_r;
   reg fcv_r;
   reg [7:0] addr_out_latch_low;
   reg [7:0] addr_out_latch_high;
   reg read_r;
   reg [7:0] dout_r;
   reg doe_n_r;
   reg sync_r;

   wire [15:0] pc;
   wire [15:0] pc_inc;
   wire [15:0] addr_full;
   wire [15:0] tgt;
   wire [15:0] tgt_inc;
   wire [8:0] cy;
   wire [7:0] sum;
   wire [7:0] alu_res;
   wire ovf;
   wire [1:0] cls;
   wire jmp;
   wire taken;
   wire wr;

   function [1:0] op_class;
      input [7:0] op;
      begin
         case (op)
            `OP_LDA_IMM, `OP_LDX_IMM, `OP_LDY_IMM, `OP_ADC_IMM,
            `OP_AND_IMM, `OP_ORA_IMM, `OP_BEQ, `OP_BNE: begin
               op_class = `CLS_TWO;
            end
            `OP_LDA_ABS, `OP_STA_ABS, `OP_JMP_ABS: begin
               op_class = `CLS_ABS;
            end
            default: begin
               op_class = `CLS_IMPL;
            end
         endcase
      end
   endfunction

   function alu_bit;
      input [1:0] f;
      input a;
      input b;
      input s;
      begin
         case (f)
            `ALU_OR: alu_bit = a | b;
            `ALU_AND: alu_bit = a & b;
            `ALU_EOR: alu_bit = a ^ b;
            default: alu_bit = s;
         endcase
      end
   endfunction

   // reset release through two flops
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rs1_r <= 1'b0;
         rs2_r <= 1'b0;
      end else begin
         rs1_r <= 1'b1;
         rs2_r <= rs1_r;
      end
   end
   assign rst_n = rs2_r;

   // per-bit alu slice, inputs from buses or zero
   genvar i;
   assign cy[0] = cin_r;
   generate
      for (i = 0; i < 8; i = i + 1) begin : g_alu
         assign sum[i] = ai_r[i] ^ bi_r[i] ^ cy[i];
         assign cy[i+1] = (ai_r[i] & bi_r[i]) | (cy[i] & (ai_r[i] ^ bi_r[i]));
         assign alu_res[i] = alu_bit(op_r, ai_r[i], bi_r[i], sum[i]);
      end
   endgenerate
   assign ovf = (ai_r[7] == bi_r[7]) && (sum[7] != ai_r[7]);

   assign pc = {fetch_pointer_high, fetch_pointer_low};
   assign pc_inc = pc + 16'h0001;

   // status latches steer the fetch target
   assign cls = op_class(ir_r);
   assign jmp = (ir_r == `OP_JMP_ABS);
   assign taken = ((ir_r == `OP_BEQ) && p_r[`P_Z]) ||
                  ((ir_r == `OP_BNE) && !p_r[`P_Z]);
   assign tgt = jmp ? {input_capture_latch, lo_r} :
                taken ? pc + {{8{input_capture_latch[7]}},
                              input_capture_latch} : pc;
   assign tgt_inc = tgt + 16'h0001;
   assign wr = (t_r == `T3) && (ir_r == `OP_STA_ABS);

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ph_r <= `PH_ONE;
         phi2_r <= 1'b0;
         t_r <= `T0;
         end_r <= 1'b0;
         ir_r <= `OP_NOP;
         input_capture_latch <= 8'h00;
         fetch_pointer_low <= RESET_PC[7:0];
         fetch_pointer_high <= RESET_PC[15:8];
         acc_r <= 8'h00;
         idx_x_r <= 8'h00;
         idx_y_r <= 8'h00;
         stk_r <= 8'h00;
         p_r <= `P_RESET;
         lo_r <= 8'h00;
         ai_r <= 8'h00;
         bi_r <= 8'h00;
         cin_r <= 1'b0;
         op_r <= `ALU_OR;
         dst_r <= `DST_NONE;
         fnz_r <= 1'b0;
         fcv_r <= 1'b0;
         addr_out_latch_low <= RESET_PC[7:0];
         addr_out_latch_high <= RESET_PC[15:8];
         read_r <= 1'b1;
         dout_r <= 8'h00;
         doe_n_r <= 1'b1;
         sync_r <= 1'b0;
      end else begin
         ph_r <= ~ph_r;
         phi2_r <= (ph_r == `PH_ONE);
         if (ph_r == `PH_TWO) begin
            // trap bus data at end of phase two
            input_capture_latch <= data_in;
            if (t_r == `T0) begin
               ir_r <= data_in;
            end
            // restart on fetch or advance state
            t_r <= end_r ? `T0 : t_r + 3'h1;
            // release data drivers before phase one
            doe_n_r <= 1'b1;
         end else begin
            // previous cycle's alu result stored now
            case (dst_r)
               `DST_A: acc_r <= alu_res;
               `DST_X: idx_x_r <= alu_res;
               `DST_Y: idx_y_r <= alu_res;
               `DST_S: stk_r <= alu_res;
               default: begin
               end
            endcase
            if (fnz_r) begin
               p_r[`P_Z] <= (alu_res == 8'h00);
               p_r[`P_N] <= alu_res[7];
            end
            if (fcv_r) begin
               p_r[`P_C] <= cy[8];
               p_r[`P_V] <= ovf;
            end
            // alu inputs loaded in phase one
            ai_r <= 8'h00;
            bi_r <= input_capture_latch;
            cin_r <= 1'b0;
            op_r <= `ALU_OR;
            dst_r <= `DST_NONE;
            fnz_r <= 1'b0;
            fcv_r <= 1'b0;
            read_r <= ~wr;
            // drive data only in a write's phase two
            doe_n_r <= ~wr;
            dout_r <= acc_r;
            sync_r <= (t_r == `T0);
            case (t_r)
               `T0: begin
                  addr_out_latch_low <= tgt[7:0];
                  addr_out_latch_high <= tgt[15:8];
                  fetch_pointer_low <= tgt_inc[7:0];
                  fetch_pointer_high <= tgt_inc[15:8];
                  end_r <= 1'b0;
                  case (ir_r)
                     `OP_LDA_IMM, `OP_LDA_ABS: begin
                        dst_r <= `DST_A;
                        fnz_r <= 1'b1;
                     end
                     `OP_LDX_IMM: begin
                        dst_r <= `DST_X;
                        fnz_r <= 1'b1;
                     end
                     `OP_LDY_IMM: begin
                        dst_r <= `DST_Y;
                        fnz_r <= 1'b1;
                     end
                     `OP_ADC_IMM: begin
                        ai_r <= acc_r;
                        cin_r <= p_r[`P_C];
                        op_r <= `ALU_SUM;
                        dst_r <= `DST_A;
                        fnz_r <= 1'b1;
                        fcv_r <= 1'b1;
                     end
                     `OP_AND_IMM: begin
                        ai_r <= acc_r;
                        op_r <= `ALU_AND;
                        dst_r <= `DST_A;
                        fnz_r <= 1'b1;
                     end
                     `OP_ORA_IMM: begin
                        ai_r <= acc_r;
                        dst_r <= `DST_A;
                        fnz_r <= 1'b1;
                     end
                     // index steps and the transfer to x done by the alu
                     `OP_INX: begin
                        ai_r <= idx_x_r;
                        bi_r <= 8'h00;
                        cin_r <= 1'b1;
                        op_r <= `ALU_SUM;
                        dst_r <= `DST_X;
                        fnz_r <= 1'b1;
                     end
                     `OP_DEX: begin
                        ai_r <= idx_x_r;
                        bi_r <= 8'hff;
                        op_r <= `ALU_SUM;
                        dst_r <= `DST_X;
                        fnz_r <= 1'b1;
                     end
                     `OP_INY: begin
                        ai_r <= idx_y_r;
                        bi_r <= 8'h00;
                        cin_r <= 1'b1;
                        op_r <= `ALU_SUM;
                        dst_r <= `DST_Y;
                        fnz_r <= 1'b1;
                     end
                     `OP_TAX: begin
                        ai_r <= acc_r;
                        bi_r <= 8'h00;
                        dst_r <= `DST_X;
                        fnz_r <= 1'b1;
                     end
                     // stack pointer loaded as plain latch
                     `OP_TXS: begin
                        ai_r <= idx_x_r;
                        bi_r <= 8'h00;
                        dst_r <= `DST_S;
                     end
                     `OP_CLC: p_r[`P_C] <= 1'b0;
                     `OP_SEC: p_r[`P_C] <= 1'b1;
                     default: begin
                     end
                  endcase
               end
               `T1: begin
                  addr_out_latch_low <= fetch_pointer_low;
                  addr_out_latch_high <= fetch_pointer_high;
                  if (cls != `CLS_IMPL) begin
                     fetch_pointer_low <= pc_inc[7:0];
                     fetch_pointer_high <= pc_inc[15:8];
                  end
                  end_r <= (cls != `CLS_ABS);
               end
               `T2: begin
                  lo_r <= input_capture_latch;
                  addr_out_latch_low <= fetch_pointer_low;
                  addr_out_latch_high <= fetch_pointer_high;
                  fetch_pointer_low <= pc_inc[7:0];
                  fetch_pointer_high <= pc_inc[15:8];
                  end_r <= jmp;
               end
               default: begin
                  addr_out_latch_low <= lo_r;
                  addr_out_latch_high <= input_capture_latch;
                  end_r <= 1'b1;
               end
            endcase
         end
      end
   end

   // address latches change only at end of phase one
   assign addr_full = {addr_out_latch_high, addr_out_latch_low};
   // narrow variants drop the upper bits
   assign address_lines = addr_full[ADDR_W-1:0];
   assign bus_read = read_r;
   assign data_out = dout_r;
   assign data_oe_n = doe_n_r;
   assign phase_two = phi2_r;
   assign fetch_cycle = sync_r;

endmodule

// >>> crsd_regs.vh
// constants for the register section and cycle sequencer
`ifndef CRSD_REGS_VH
`define CRSD_REGS_VH

// bus phases, one clock each
`define PH_ONE 1'b0
`define PH_TWO 1'b1

// cycle states
`define T0 3'h0
`define T1 3'h1
`define T2 3'h2
`define T3 3'h3

// instruction length classes
`define CLS_IMPL 2'h0
`define CLS_TWO 2'h1
`define CLS_ABS 2'h2

// opcodes
`define OP_NOP 8'hea
`define OP_LDA_IMM 8'ha9
`define OP_LDX_IMM 8'ha2
`define OP_LDY_IMM 8'ha0
`define OP_ADC_IMM 8'h69
`define OP_AND_IMM 8'h29
`define OP_ORA_IMM 8'h09
`define OP_INX 8'he8
`define OP_DEX 8'hca
`define OP_INY 8'hc8
`define OP_TAX 8'haa
`define OP_TXS 8'h9a
`define OP_CLC 8'h18
`define OP_SEC 8'h38
`define OP_BEQ 8'hf0
`define OP_BNE 8'hd0
`define OP_LDA_ABS 8'had
`define OP_STA_ABS 8'h8d
`define OP_JMP_ABS 8'h4c

// alu functions
`define ALU_OR 2'h0
`define ALU_AND 2'h1
`define ALU_EOR 2'h2
`define ALU_SUM 2'h3

// alu result destinations
`define DST_NONE 3'h0
`define DST_A 3'h1
`define DST_X 3'h2
`define DST_Y 3'h3
`define DST_S 3'h4

// status bit positions and reset values
`define P_C 0
`define P_Z 1
`define P_V 6
`define P_N 7
`define P_RESET 8'h00
`define PC_RESET 16'h0000

`endif

// >>> crsd_core_chk.sv
// bus timing checker for the register section
`timescale 1ns/10ps
module crsd_core_chk #(
   parameter ADDR_W = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // system bus
   input wire logic [ADDR_W-1:0] address_lines,
   input wire logic bus_read,
   input wire logic data_oe_n,
   // cycle timing
   input wire logic phase_two,
   input wire logic fetch_cycle
);
   localparam [ADDR_W-1:0] addr_one = 1;
   logic [1:0] live_r = 2'h0;
   wire live = live_r == 2'h3;

   // wait out the internal reset synchroniser
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         live_r <= 2'h0;
      end else if (!live) begin
         live_r <= live_r + 2'h1;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!live);

   addr_hold_a: assert property (
      $changed(address_lines) |-> phase_two)
      else $error("address moved outside the launch edge");
   rw_hold_a: assert property (
      phase_two |=> $stable(bus_read))
      else $error("read/write moved at end of phase two");
   phase_alt_a: assert property (
      phase_two != $past(phase_two))
      else $error("phases did not alternate");
   oe_write_a: assert property (
      !data_oe_n |-> phase_two && !bus_read)
      else $error("data bus driven outside a write phase two");
   write_oe_a: assert property (
      phase_two && !bus_read |-> !data_oe_n)
      else $error("write cycle without data drive");
   fetch_read_a: assert property (
      fetch_cycle |-> bus_read)
      else $error("opcode fetch was not a read");
   fetch_step_a: assert property (
      fetch_cycle && phase_two |->
         ##3 address_lines == $past(address_lines, 3) + addr_one)
      else $error("no step of fetch pointer after opcode fetch");
   instr_len_a: assert property (
      $fell(fetch_cycle) |-> !fetch_cycle ##1 !fetch_cycle
         ##[1:5] fetch_cycle)
      else $error("instruction length out of range");
endmodule

// >>> crsd_mem.sv
// program and data memory on the far side of the system bus
`timescale 1ns/10ps
module crsd_mem (
   // clock
   input wire logic clk,
   // bus from the processor
   input wire logic [15:0] address_lines,
   input wire logic bus_read,
   input wire logic phase_two,
   input wire logic data_oe_n,
   input wire logic [7:0] data_out,
   // read data
   output logic [7:0] data_in
);
   logic [7:0] mem [0:65535];

   initial begin
      data_in = 8'h00;
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 8'h00;
      end
   end

   // valid only in a read phase two, toggling junk otherwise
   always @(negedge clk) begin
      if (phase_two && bus_read) begin
         data_in <= mem[address_lines];
      end else begin
         data_in <= ~data_in;
      end
      if (!data_oe_n) begin
         mem[address_lines] = data_out;
      end
   end
endmodule

// >>> crsd_tb.sv
// self-checking bench for the register section datapath
`timescale 1ns/10ps
module testbench;
   logic clk;
   logic nrst;
   wire [15:0] address_lines;
   wire bus_read;
   wire [7:0] data_in;
   wire [7:0] data_out;
   wire data_oe_n;
   wire phase_two;
   wire fetch_cycle;
   int error_cnt;
   int n_checks;
   int cyc;
   logic [7:0] prog [0:20] = '{8'ha9, 8'h05, 8'h69, 8'h03, 8'h8d, 8'h00,
      8'h02, 8'h29, 8'h0c, 8'h09, 8'h01, 8'h8d, 8'h01, 8'h02, 8'hd0,
      8'h02, 8'h00, 8'h00, 8'h4c, 8'h12, 8'h00};
   logic [15:0] fetches [0:8] = '{16'h0000, 16'h0002, 16'h0004,
      16'h0007, 16'h0009, 16'h000b, 16'h000e, 16'h0012, 16'h0012};
   logic [7:0] prog2 [0:38] = '{8'ha0, 8'hff, 8'hc8, 8'hf0, 8'h01,
      8'h00, 8'ha2, 8'h01, 8'hca, 8'hd0, 8'h01, 8'h9a, 8'hf0, 8'h01,
      8'h00, 8'h38, 8'ha9, 8'hff, 8'h69, 8'h01, 8'h00, 8'h8d, 8'h02,
      8'h02, 8'had, 8'h02, 8'h02, 8'h18, 8'h69, 8'hfe, 8'h8d, 8'h03,
      8'h02, 8'haa, 8'hf0, 8'h01, 8'h4c, 8'h24, 8'h00};
   logic [15:0] fetches2 [0:20] = '{16'h0000, 16'h0002, 16'h0003,
      16'h0006, 16'h0008, 16'h0009, 16'h000b, 16'h000c, 16'h000f,
      16'h0010, 16'h0012, 16'h0014, 16'h0015, 16'h0018, 16'h001b,
      16'h001c, 16'h001e, 16'h0021, 16'h0022, 16'h0024, 16'h0024};

   crsd_core #(.ADDR_W(16)) i_dut (.clk(clk), .nrst(nrst),
      .address_lines(address_lines), .bus_read(bus_read),
      .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
      .phase_two(phase_two), .fetch_cycle(fetch_cycle));
   crsd_mem i_mem (.clk(clk), .address_lines(address_lines),
      .bus_read(bus_read), .phase_two(phase_two),
      .data_oe_n(data_oe_n), .data_out(data_out), .data_in(data_in));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input string what, input logic [15:0] exp,
         input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic results();
      if (error_cnt == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // program image; result cells preset so a lost store shows
   task automatic load_prog();
      for (int i = 0; i < 21; i++) begin
         i_mem.mem[i] = prog[i];
      end
      i_mem.mem[16'h0200] = 8'hff;
      i_mem.mem[16'h0201] = 8'hff;
   endtask

   task automatic t_reset_state();
      chk("reset address", 16'h0000, address_lines);
      chk("reset read", 16'h0001, {15'h0000, bus_read});
      chk("reset drive", 16'h0001, {15'h0000, data_oe_n});
      chk("reset phase", 16'h0000, {15'h0000, phase_two});
      chk("reset fetch", 16'h0000, {15'h0000, fetch_cycle});
   endtask

   task automatic next_fetch(output logic [15:0] a);
      int n;
      n = 0;
      @(negedge clk);
      while (!(fetch_cycle === 1'b1 && phase_two === 1'b1) && n < 20) begin
         @(negedge clk);
         n++;
      end
      a = address_lines;
   endtask

   // straight code, a taken branch and a jump to itself
   task automatic t_fetch_order();
      logic [15:0] a;
      for (int i = 0; i < 9; i++) begin
         next_fetch(a);
         chk("fetch address", fetches[i], a);
      end
   endtask

   task automatic t_stores();
      chk("sum stored", 16'h0008, {8'h00, i_mem.mem[16'h0200]});
      chk("logic stored", 16'h0009, {8'h00, i_mem.mem[16'h0201]});
   endtask

   // reset lands in the middle of an instruction, then the run repeats
   task automatic t_abort_rerun();
      nrst = 1'b0;
      load_prog();
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      repeat (7) @(negedge clk);
      nrst = 1'b0;
      @(negedge clk);
      t_reset_state();
      @(negedge clk);
      nrst = 1'b1;
      t_fetch_order();
      t_stores();
   endtask

   // index steps, flag branches, carry and absolute load on a second image
   task automatic t_prog_two();
      logic [15:0] a;
      nrst = 1'b0;
      for (int i = 0; i < 39; i++) begin
         i_mem.mem[i] = prog2[i];
      end
      i_mem.mem[16'h0202] = 8'h00;
      i_mem.mem[16'h0203] = 8'h00;
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      for (int i = 0; i < 21; i++) begin
         next_fetch(a);
         chk("second fetch", fetches2[i], a);
      end
      chk("carry sum", 16'h0001, {8'h00, i_mem.mem[16'h0202]});
      chk("clear carry sum", 16'h00ff, {8'h00, i_mem.mem[16'h0203]});
   endtask

   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         error_cnt++;
         results();
      end
   end

   initial begin
      nrst = 1'b0;
      error_cnt = 0;
      n_checks = 0;
      cyc = 0;
      #1;
      load_prog();
      repeat (2) @(negedge clk);
      t_reset_state();
      nrst = 1'b1;
      t_fetch_order();
      t_stores();
      t_abort_rerun();
      t_prog_two();
      results();
   end
endmodule

bind crsd_core crsd_core_chk #(.ADDR_W(ADDR_W)) i_chk (.clk(clk),
   .nrst(nrst), .address_lines(address_lines), .bus_read(bus_read),
   .data_oe_n(data_oe_n), .phase_two(phase_two),
   .fetch_cycle(fetch_cycle));
